// ==== hdl/vagr_consts.svh ====
`ifndef VAGR_CONSTS_SVH
`define VAGR_CONSTS_SVH

// register indices; byte address is four times the index
`define VAGR_IDX_INPUT_CFG 8'h05
`define VAGR_IDX_RED_GAIN 8'h06
`define VAGR_IDX_GREEN_GAIN 8'h07
`define VAGR_IDX_BLUE_GAIN 8'h08
`define VAGR_IDX_RED_OFFSET 8'h09
`define VAGR_IDX_GREEN_OFFSET 8'h0A
`define VAGR_IDX_BLUE_OFFSET 8'h0B
`define VAGR_IDX_OFFSET_CFG 8'h0C
`define VAGR_IDX_CLAMP_CTRL 8'h20
`define VAGR_IDX_STATUS 8'h21

`define VAGR_RST_INPUT_CFG 8'h00
`define VAGR_RST_GAIN 8'h55
`define VAGR_RST_OFFSET 8'h80
`define VAGR_RST_OFFSET_CFG 8'h00
`define VAGR_RST_CLAMP_CTRL 8'h00

`define VAGR_MASK_INPUT_CFG 8'h3F
`define VAGR_MASK_OFFSET_CFG 8'hFD
`define VAGR_MASK_CLAMP_CTRL 8'h03

`define VAGR_CFG_PORT 0
`define VAGR_CFG_COUPLING 1
`define VAGR_CFG_YUV 2
`define VAGR_CFG_SYNC_TYPE 3
`define VAGR_CFG_CS_SRC 4
`define VAGR_CFG_HOLD_CLAMP 5
`define VAGR_OCFG_RANGE 0
`define VAGR_OCFG_LSB_LO 2
`define VAGR_CTRL_ABL_EN 0
`define VAGR_CTRL_DCR_EN 1

`define VAGR_DAC_MID 10'h200
`define VAGR_TARGET_CHROMA 8'h80
`define VAGR_TARGET_BASE 8'h00
`endif

// ==== hdl/vagr_pkg.sv ====
package vagr_pkg;
  typedef enum logic [1:0] {
    VAGR_OKAY = 2'h0,
    VAGR_SLVERR = 2'h2
  } vagr_resp_t;
  typedef enum logic [3:0] {
    SL_INCFG = 4'h0, SL_RGAIN = 4'h1, SL_GGAIN = 4'h2, SL_BGAIN = 4'h3,
    SL_ROFF = 4'h4, SL_GOFF = 4'h5, SL_BOFF = 4'h6, SL_OCFG = 4'h7,
    SL_CTRL = 4'h8, SL_STAT = 4'h9, SL_NONE = 4'hF
  } vagr_slot_t;
endpackage

// ==== hdl/vagr_chan.sv ====
`timescale 1ns/100ps
`include "vagr_consts.svh"
module vagr_chan #(
  parameter bit IS_GREEN = 1'b0,
  parameter bit IS_CHROMA = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] gain_reg,
  input wire logic [7:0] offset_reg,
  input wire logic [1:0] dac_lsbs,
  input wire logic yuv,
  input wire logic abl_en,
  input wire logic load_tick,
  output logic [7:0] gain_code,
  output logic [9:0] dac_code,
  output logic [7:0] digital_offset,
  output logic clamp_600mv,
  output logic half_shift,
  output logic [7:0] target_code
);
  wire logic chroma = yuv && IS_CHROMA;
  wire logic [9:0] manual_code = {offset_reg, dac_lsbs};
  wire logic [7:0] signed_off = offset_reg ^ 8'h80;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gain_code <= `VAGR_RST_GAIN;
      dac_code <= `VAGR_DAC_MID;
      digital_offset <= 8'h00;
      clamp_600mv <= 1'b0;
      half_shift <= 1'b1;
      target_code <= `VAGR_TARGET_BASE;
    end else begin
      gain_code <= gain_reg;
      clamp_600mv <= chroma;
      half_shift <= !yuv || IS_GREEN;
      target_code <= chroma ? `VAGR_TARGET_CHROMA : `VAGR_TARGET_BASE;
      if (load_tick) begin
        dac_code <= abl_en ? `VAGR_DAC_MID : manual_code;
        digital_offset <= abl_en ? signed_off : 8'h00;
      end
    end
  end

  a_dac_load: assert property (
    @(posedge aclk) disable iff (!aresetn)
    load_tick && !abl_en |=> dac_code == $past(manual_code))
    else $error("offset converter not loaded on clamp pulse");
  a_dac_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !load_tick |=> $stable(dac_code))
    else $error("offset converter changed without clamp pulse");
  a_digital_offset: assert property (
    @(posedge aclk) disable iff (!aresetn)
    load_tick && abl_en |=> digital_offset == ($past(offset_reg) ^ 8'h80))
    else $error("digital offset encoding wrong");
  a_target_code: assert property (
    @(posedge aclk) disable iff (!aresetn)
    yuv |=> target_code == (IS_CHROMA ? 8'h80 : 8'h00))
    else $error("colour space target code wrong");
endmodule

// ==== hdl/vagr_regs.sv ====
`timescale 1ns/100ps
`include "vagr_consts.svh"
module vagr_regs #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic hsync_in,
  input wire logic vsync_in,
  input wire logic green_embedded_sync_input,
  input wire logic clamp_pulse_in,
  input wire logic pll_holdover_in,
  output logic input_port_two_sel,
  output logic pos_to_clamp,
  output logic neg_to_pad,
  output logic neg_tied_clamp,
  output logic analog_clamp,
  output logic abl_run,
  output logic composite_sync_mode,
  output logic composite_sync_signal,
  output logic vsync_out,
  output logic offset_range_quarter,
  output logic [2:0][7:0] chan_gain,
  output logic [2:0][9:0] chan_dac,
  output logic [2:0][7:0] chan_digital_offset,
  output logic [2:0] chan_clamp_600mv,
  output logic [2:0] chan_half_shift,
  output logic [2:0][7:0] chan_target
);
  localparam int NPIN = 5;
  localparam int P_HS = 0;
  localparam int P_VS = 1;
  localparam int P_SOG = 2;
  localparam int P_CLAMP = 3;
  localparam int P_HOLD = 4;

  // map a byte address onto a storage slot
  function automatic vagr_pkg::vagr_slot_t slot_of(input logic [ADDR_W-1:0] a);
    logic [7:0] idx;
    idx = 8'(a >> 2);
    if (a[1:0] != 2'b00)
      return vagr_pkg::SL_NONE;
    case (idx)
      `VAGR_IDX_INPUT_CFG: return vagr_pkg::SL_INCFG;
      `VAGR_IDX_RED_GAIN: return vagr_pkg::SL_RGAIN;
      `VAGR_IDX_GREEN_GAIN: return vagr_pkg::SL_GGAIN;
      `VAGR_IDX_BLUE_GAIN: return vagr_pkg::SL_BGAIN;
      `VAGR_IDX_RED_OFFSET: return vagr_pkg::SL_ROFF;
      `VAGR_IDX_GREEN_OFFSET: return vagr_pkg::SL_GOFF;
      `VAGR_IDX_BLUE_OFFSET: return vagr_pkg::SL_BOFF;
      `VAGR_IDX_OFFSET_CFG: return vagr_pkg::SL_OCFG;
      `VAGR_IDX_CLAMP_CTRL: return vagr_pkg::SL_CTRL;
      `VAGR_IDX_STATUS: return vagr_pkg::SL_STAT;
      default: return vagr_pkg::SL_NONE;
    endcase
  endfunction

  function automatic logic [7:0] rst_of(input int s);
    case (s)
      0: return `VAGR_RST_INPUT_CFG;
      1, 2, 3: return `VAGR_RST_GAIN;
      4, 5, 6: return `VAGR_RST_OFFSET;
      7: return `VAGR_RST_OFFSET_CFG;
      default: return `VAGR_RST_CLAMP_CTRL;
    endcase
  endfunction

  // reserved bits are never stored, so they read back zero
  function automatic logic [7:0] mask_of(input int s);
    case (s)
      0: return `VAGR_MASK_INPUT_CFG;
      7: return `VAGR_MASK_OFFSET_CFG;
      8: return `VAGR_MASK_CLAMP_CTRL;
      default: return 8'hFF;
    endcase
  endfunction

  logic [7:0] regs [0:8];
  logic [NPIN-1:0] pin_s1;
  logic [NPIN-1:0] pin_s2;
  logic clamp_d;
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // pin synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      clamp_d <= 1'b0;
    end else begin
      pin_s1 <= {pll_holdover_in, clamp_pulse_in, green_embedded_sync_input,
                 vsync_in, hsync_in};
      pin_s2 <= pin_s1;
      clamp_d <= pin_s2[P_CLAMP];
    end
  end

  wire logic hs_s = pin_s2[P_HS];
  wire logic vs_s = pin_s2[P_VS];
  wire logic sog_s = pin_s2[P_SOG];
  wire logic hold_s = pin_s2[P_HOLD];
  wire logic clamp_tick = pin_s2[P_CLAMP] && !clamp_d;

  wire logic [7:0] in_cfg = regs[0];
  wire logic [7:0] ocfg = regs[7];
  wire logic [7:0] ctrl = regs[8];
  wire logic abl_en = ctrl[`VAGR_CTRL_ABL_EN];
  wire logic dcr_en = ctrl[`VAGR_CTRL_DCR_EN];
  wire logic dc_cpl = in_cfg[`VAGR_CFG_COUPLING];
  wire logic sync_comp = in_cfg[`VAGR_CFG_SYNC_TYPE];
  wire logic cs_from_hs = in_cfg[`VAGR_CFG_CS_SRC];

  wire logic clamp_allowed = !hold_s || in_cfg[`VAGR_CFG_HOLD_CLAMP];
  wire logic next_analog_clamp = clamp_tick && dcr_en && clamp_allowed && !dc_cpl;
  wire logic next_abl_run = clamp_tick && abl_en && clamp_allowed;
  wire logic next_css = (sync_comp && !cs_from_hs) ? sog_s : hs_s;

  // write channel: address and data taken in either order
  wire logic aw_fire = s_axi_awvalid && s_axi_awready;
  wire logic w_fire = s_axi_wvalid && s_axi_wready;
  wire logic wr_go = aw_held && w_held && !s_axi_bvalid;
  wire vagr_pkg::vagr_slot_t wr_slot = slot_of(aw_addr_q);
  wire vagr_pkg::vagr_slot_t rd_slot = slot_of(s_axi_araddr);
  wire logic ar_fire = s_axi_arvalid && s_axi_arready;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= vagr_pkg::VAGR_OKAY;
    end else begin
      if (aw_fire) begin
        aw_held <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_held <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_slot == vagr_pkg::SL_NONE) ? vagr_pkg::VAGR_SLVERR
                                                      : vagr_pkg::VAGR_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // storage, only byte lane 0 carries data
  generate
    for (genvar s = 0; s < 9; s++) begin : g_reg
      always_ff @(posedge aclk) begin
        if (!aresetn)
          regs[s] <= rst_of(s);
        else if (wr_go && wstrb_q[0] && wr_slot == vagr_pkg::vagr_slot_t'(s))
          regs[s] <= wdata_q[7:0] & mask_of(s);
      end
    end
  endgenerate

  wire logic [7:0] status = {2'b00, abl_run, composite_sync_signal, hold_s,
                             sog_s, vs_s, hs_s};
  wire logic [7:0] rd_byte = (rd_slot == vagr_pkg::SL_STAT) ? status :
                             (rd_slot == vagr_pkg::SL_NONE) ? 8'h00 :
                             regs[rd_slot];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= vagr_pkg::VAGR_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= (rd_slot == vagr_pkg::SL_NONE) ? vagr_pkg::VAGR_SLVERR
                                                    : vagr_pkg::VAGR_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // analog steering outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_port_two_sel <= 1'b0;
      pos_to_clamp <= 1'b0;
      neg_to_pad <= 1'b0;
      neg_tied_clamp <= 1'b1;
      analog_clamp <= 1'b0;
      abl_run <= 1'b0;
      composite_sync_mode <= 1'b0;
      composite_sync_signal <= 1'b0;
      vsync_out <= 1'b0;
      offset_range_quarter <= 1'b0;
    end else begin
      input_port_two_sel <= in_cfg[`VAGR_CFG_PORT];
      pos_to_clamp <= next_analog_clamp;
      neg_to_pad <= dc_cpl;
      neg_tied_clamp <= !dc_cpl;
      analog_clamp <= next_analog_clamp;
      abl_run <= next_abl_run;
      composite_sync_mode <= sync_comp;
      composite_sync_signal <= next_css;
      vsync_out <= vs_s;
      offset_range_quarter <= ocfg[`VAGR_OCFG_RANGE];
    end
  end

  // per-channel datapath; 0 red, 1 green, 2 blue
  generate
    for (genvar c = 0; c < 3; c++) begin : g_chan
      vagr_chan #(
        .IS_GREEN(c == 1),
        .IS_CHROMA(c != 1)
      ) vagr_chan_i (
        .aclk(aclk),
        .aresetn(aresetn),
        .gain_reg(regs[1 + c]),
        .offset_reg(regs[4 + c]),
        .dac_lsbs(ocfg[`VAGR_OCFG_LSB_LO + 2 * c +: 2]),
        .yuv(in_cfg[`VAGR_CFG_YUV]),
        .abl_en(abl_en),
        .load_tick(clamp_tick),
        .gain_code(chan_gain[c]),
        .dac_code(chan_dac[c]),
        .digital_offset(chan_digital_offset[c]),
        .clamp_600mv(chan_clamp_600mv[c]),
        .half_shift(chan_half_shift[c]),
        .target_code(chan_target[c])
      );
    end
  endgenerate

  a_cfg_store: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_go && wstrb_q[0] && wr_slot == vagr_pkg::SL_INCFG
      |=> in_cfg == ($past(wdata_q[7:0]) & 8'h3F))
    else $error("input configuration not stored");
  a_rd_reserved: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ar_fire && rd_slot == vagr_pkg::SL_INCFG
      |=> s_axi_rvalid && s_axi_rdata == {24'h00_0000, $past(in_cfg)}
          && s_axi_rdata[7:6] == 2'b00)
    else $error("input configuration readback wrong");
  a_ac_coupling: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !dc_cpl |=> neg_tied_clamp && !neg_to_pad)
    else $error("ac coupling steering wrong");
  a_dc_coupling: assert property (
    @(posedge aclk) disable iff (!aresetn)
    dc_cpl |=> !analog_clamp && !pos_to_clamp && neg_to_pad)
    else $error("dc coupling still clamps");
  a_sync_separate: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !sync_comp |=> composite_sync_signal == $past(hs_s))
    else $error("separate sync does not pass horizontal sync");
  a_sync_green: assert property (
    @(posedge aclk) disable iff (!aresetn)
    sync_comp && !cs_from_hs |=> composite_sync_signal == $past(sog_s))
    else $error("composite sync not from green input");
  a_hold_suspend: assert property (
    @(posedge aclk) disable iff (!aresetn)
    hold_s && !in_cfg[`VAGR_CFG_HOLD_CLAMP] |=> !abl_run && !analog_clamp)
    else $error("clamp ran during holdover");
  a_write_resp: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_go |=> s_axi_bvalid ##1 (s_axi_bvalid || $past(s_axi_bready)))
    else $error("write response dropped early");
endmodule

// ==== sim/vagr_src.sv ====
`timescale 1ns/100ps
module vagr_src (
  input wire logic aclk,
  input wire logic hs_lvl,
  input wire logic gs_lvl,
  input wire logic fire,
  input wire logic hold_lvl,
  output logic hsync_in,
  output logic vsync_in,
  output logic green_embedded_sync_input,
  output logic clamp_pulse_in,
  output logic pll_holdover_in
);
  logic [1:0] cnt = 2'h0;
  // clamp pin held high three cycles so the synchroniser cannot miss it
  always @(posedge aclk) begin
    hsync_in <= hs_lvl;
    vsync_in <= ~hs_lvl;
    green_embedded_sync_input <= gs_lvl;
    pll_holdover_in <= hold_lvl;
    cnt <= fire ? 2'h3 : cnt - 2'(cnt != 2'h0);
    clamp_pulse_in <= (cnt != 2'h0);
  end
endmodule

// ==== sim/video_afe_input_gain_offset_regs_tb.sv ====
`timescale 1ns/100ps
module video_afe_input_gain_offset_regs_tb;
  localparam logic [7:0] RV [8] = '{8'h00, 8'h55, 8'h55, 8'h55, 8'h80, 8'h80, 8'h80, 8'h00};
  localparam logic [7:0] MK [8] = '{8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFD};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic hs_lvl = 1'b0, gs_lvl = 1'b0, fire = 1'b0, hold_lvl = 1'b0;
  logic hsync_in, vsync_in, gsync, clamp_in, hold_in;
  logic port2, neg_pad, ntc, cs_mode, cs_sig, orq;
  logic p2c, aclamp, ablr, vs_o;
  logic [2:0][7:0] gain, doff, target;
  logic [2:0][9:0] dac;
  logic [2:0] c600, hshift;
  logic [33:0] q[$];
  logic [31:0] seed = 32'h2A3A;
  logic [7:0] v [8];
  int mismatches = 0;
  int samples_checked = 0;
  int n_clamp = 0, n_pos = 0, n_abl = 0;
  int e_clamp = 0, e_abl = 0;

  always #12.5 aclk = ~aclk;

  vagr_src vagr_src_i (.aclk(aclk), .hs_lvl(hs_lvl), .gs_lvl(gs_lvl), .fire(fire),
    .hold_lvl(hold_lvl),
    .hsync_in(hsync_in), .vsync_in(vsync_in), .green_embedded_sync_input(gsync),
    .clamp_pulse_in(clamp_in), .pll_holdover_in(hold_in));

  vagr_regs vagr_regs_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .hsync_in(hsync_in), .vsync_in(vsync_in),
    .green_embedded_sync_input(gsync), .clamp_pulse_in(clamp_in), .pll_holdover_in(hold_in),
    .input_port_two_sel(port2), .pos_to_clamp(p2c), .neg_to_pad(neg_pad),
    .neg_tied_clamp(ntc), .analog_clamp(aclamp), .abl_run(ablr), .composite_sync_mode(cs_mode),
    .composite_sync_signal(cs_sig), .vsync_out(vs_o), .offset_range_quarter(orq),
    .chan_gain(gain), .chan_dac(dac), .chan_digital_offset(doff),
    .chan_clamp_600mv(c600), .chan_half_shift(hshift), .chan_target(target));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic final_report();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // bounded wait ran out: count it and stop
  task automatic hang();
    mismatches++;
    final_report();
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ta, tw, done;
    done = 1'b0;
    q.push_back({er, 32'h0});
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge aclk);
      ta = awready;
      tw = wready;
      done = bvalid;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (done) bready <= 1'b0;
    end
    if (!done) hang();
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    logic ta, done;
    done = 1'b0;
    q.push_back(e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge aclk);
      ta = arready;
      done = rvalid;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (done) rready <= 1'b0;
    end
    if (!done) hang();
  endtask

  // responses are matched in order against the oldest note
  always @(posedge aclk) begin
    if ((bvalid && bready) || (rvalid && rready)) begin
      if (q.size() == 0) check(34'h0, 34'h1);
      else if (bvalid) check({bresp, 32'h0}, q.pop_front());
      else check({rresp, rdata}, q.pop_front());
    end
  end

  // clamp and compensation pulses last one cycle; count them once reset is gone
  always @(posedge aclk) begin
    if (aresetn) begin
      n_clamp <= n_clamp + int'(aclamp);
      n_pos <= n_pos + int'(p2c);
      n_abl <= n_abl + int'(ablr);
    end
  end

  initial begin
    logic [7:0] c;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++) rd(8'h14 + 8'(4 * i), {26'h0, RV[i]});
    rd(8'h40, {2'h2, 32'h0});
    wr(8'h15, 8'hAA, 2'h2);
    for (int i = 0; i < 8; i++) begin
      c = 8'(xs());
      v[i] = c & MK[i];
      wr(8'h14 + 8'(4 * i), c, 2'h0);
      rd(8'h14 + 8'(4 * i), {26'h0, v[i]});
    end
    for (int i = 0; i < 3; i++) check(34'(gain[i]), 34'(v[i + 1]));
    check(34'(orq), 34'(v[7][0]));
    // every input configuration, sync pins randomised each pass
    for (int j = 0; j < 64; j++) begin
      c = 8'(j);
      {hs_lvl, gs_lvl} <= 2'(xs());
      wr(8'h14, c, 2'h0);
      repeat (4) @(posedge aclk);
      check(34'(ntc), 34'(!c[1]));
      check(34'(neg_pad), 34'(c[1]));
      check(34'({c600, hshift, target}),
        c[2] ? 34'({3'h5, 3'h2, 24'h800080}) : 34'({3'h0, 3'h7, 24'h0}));
      check(34'({port2, cs_mode, cs_sig}),
        34'({c[0], c[3], (c[3] && !c[4]) ? gs_lvl : hs_lvl}));
      check(34'(vs_o), 34'(!hs_lvl));
    end
    // converters load on every clamp edge; clamp pulses only when enabled, ac coupled
    // and not suspended by holdover; compensation pulses when enabled and not suspended
    for (int k = 0; k < 32; k++) begin
      hold_lvl <= k[2];
      wr(8'h14, 8'({k[3], 3'h0, k[4], 1'b0}), 2'h0);
      wr(8'h80, 8'(k[1:0]), 2'h0);
      rd(8'h84, {29'h0, hs_lvl, k[2], gs_lvl, !hs_lvl, hs_lvl});
      if (k[1] && !k[4] && (!k[2] || k[3])) e_clamp++;
      if (k[0] && (!k[2] || k[3])) e_abl++;
      @(posedge aclk);
      fire <= 1'b1;
      @(posedge aclk);
      fire <= 1'b0;
      repeat (10) @(posedge aclk);
      for (int ch = 0; ch < 3; ch++) begin
        check(34'(dac[ch]),
          k[0] ? 34'(10'h200) : 34'({v[4 + ch], v[7][2 * ch + 2 +: 2]}));
        check(34'(doff[ch]), k[0] ? 34'(v[4 + ch] ^ 8'h80) : 34'h0);
      end
      check(34'(n_clamp), 34'(e_clamp));
      check(34'(n_pos), 34'(e_clamp));
      check(34'(n_abl), 34'(e_abl));
    end
    final_report();
  end
endmodule
